//--- pkg/sbsp_defs.svh
`ifndef SBSP_DEFS_SVH
`define SBSP_DEFS_SVH

`define SBSP_ADDR_W 10
`define SBSP_BYTES 4
`define SBSP_BYTE_W 8
`define SBSP_BURST_INC 2'h1
`define SBSP_BURST_RST 2'h0

`endif

//--- pkg/sbsp_pkg.sv
package sbsp_pkg;
  typedef enum logic [1:0] {
    SBSP_IDLE,
    SBSP_READ,
    SBSP_WRITE
  } sbsp_cyc_t;
endpackage : sbsp_pkg

//--- logic/sbsp_mem.sv
`timescale 1ns/1ps
module sbsp_mem #(
  parameter int AW = 10,
  parameter int LANES = 4,
  parameter int LW = 9
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic [AW-1:0] waddr_i,
  input wire logic [LANES-1:0] wen_i,
  input wire logic [LANES*LW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [LANES*LW-1:0] rdata_o
);
  // Each lane owns its array and read register, so no array has two writers
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LW-1:0] lane_mem [0:(1<<AW)-1];
      logic [LW-1:0] lane_q;
      always_ff @(posedge clk_i) begin
        if (wen_i[g]) begin
          lane_mem[waddr_i] <= wdata_i[g*LW +: LW];
        end
        lane_q <= lane_mem[raddr_i];
      end
      assign rdata_o[g*LW +: LW] = lane_q;
    end
  endgenerate
endmodule : sbsp_mem

//--- logic/sbsp_port.sv
`timescale 1ns/1ps
`include "sbsp_defs.svh"
// Contract
// - Burst advance steps the internal burst address each sampled edge.
// - Processor strobe low captures address, loads low bits into counter.
// - Controller strobe low captures address, loads low bits into counter.
// - Both strobes low, primary select low: processor strobe wins, controller strobe ignored.
// - Processor strobe ignored while primary chip select is high.
// - Sleep input high idles the device, data kept; low means normal.
// - Incoming data lines are registered on the rising edge.
// - Read drives data of the location addressed at the previous edge.
// - Output enable low drives data and parity; high floats them.
// - Outputs float in write data phase, first cycle after deselect, deselected.
// - Parity lanes behave as data, written per their byte select.
// - Order strap low linear, high interleaved; strap kept static.
// - All-bytes write low writes every byte regardless of selects.
// - Byte selects count only with byte-write qualifier low.
// - Chip selects evaluated only when a new address loads.
module sbsp_port #(
  parameter int ADDR_W = `SBSP_ADDR_W,
  parameter int BYTES = `SBSP_BYTES,
  parameter int BYTE_W = `SBSP_BYTE_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Address and strobes
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  // Chip selects
  input wire logic chip_sel_primary_n_i,
  input wire logic chip_sel_expand_hi_i,
  input wire logic chip_sel_expand_lo_n_i,
  // Write controls
  input wire logic all_bytes_write_n_i,
  input wire logic byte_write_qual_n_i,
  input wire logic [BYTES-1:0] byte_select_n_i,
  // Static and asynchronous controls
  input wire logic burst_order_i,
  input wire logic sleep_req_i,
  input wire logic out_en_n_i,
  // Data lines
  input wire logic [BYTES*BYTE_W-1:0] data_io_i,
  output logic [BYTES*BYTE_W-1:0] data_io_o,
  output logic data_io_oe_o,
  // Parity lines
  input wire logic [BYTES-1:0] parity_io_i,
  output logic [BYTES-1:0] parity_io_o,
  output logic parity_io_oe_o,
  // Status
  output logic sleep_o
);
  localparam int LW = BYTE_W + 1;

  sbsp_pkg::sbsp_cyc_t cyc_r, cyc_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [1:0] start_r, start_nxt;
  logic [1:0] step_r, step_nxt;
  logic sel_r, sel_nxt;
  logic first_r, first_nxt;
  logic burst_ctrl_r, burst_ctrl_nxt;
  logic [BYTES-1:0] wen;
  logic [BYTES*LW-1:0] wdata;
  logic [BYTES*LW-1:0] rdata;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [1:0] burst_lo;
  logic proc_go, ctrl_go, load, chip_on, wr_req, advance, drive;

  assign sleep_o = sleep_req_i;
  assign proc_go = !proc_addr_strobe_n_i && !chip_sel_primary_n_i && !sleep_req_i;
  assign ctrl_go = !ctrl_addr_strobe_n_i && !proc_go && !sleep_req_i;
  assign load = proc_go || ctrl_go;
  assign chip_on = !chip_sel_primary_n_i && chip_sel_expand_hi_i && !chip_sel_expand_lo_n_i;
  assign wr_req = !all_bytes_write_n_i || (!byte_write_qual_n_i && !(&byte_select_n_i));
  assign advance = !burst_advance_n_i && !sleep_req_i && !load && sel_r;

  always_comb begin
    if (burst_order_i) begin
      burst_lo = start_r ^ step_r;
    end else begin
      burst_lo = start_r + step_r;
    end
    cur_addr = {base_r[ADDR_W-1:2], burst_lo};
  end

  always_comb begin
    cyc_nxt = cyc_r;
    base_nxt = base_r;
    start_nxt = start_r;
    step_nxt = step_r;
    sel_nxt = sel_r;
    first_nxt = 1'b0;
    burst_ctrl_nxt = burst_ctrl_r;
    if (load) begin
      base_nxt = addr_i;
      start_nxt = addr_i[1:0];
      step_nxt = `SBSP_BURST_RST;
      sel_nxt = chip_on;
      first_nxt = chip_on && !sel_r;
      burst_ctrl_nxt = ctrl_go;
      if (!chip_on) begin
        cyc_nxt = sbsp_pkg::SBSP_IDLE;
      end else if (ctrl_go && wr_req) begin
        cyc_nxt = sbsp_pkg::SBSP_WRITE;
      end else begin
        cyc_nxt = sbsp_pkg::SBSP_READ;
      end
    end else if (sel_r && !sleep_req_i) begin
      if (advance) begin
        step_nxt = step_r + `SBSP_BURST_INC;
      end
      cyc_nxt = wr_req ? sbsp_pkg::SBSP_WRITE : sbsp_pkg::SBSP_READ;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_r <= sbsp_pkg::SBSP_IDLE;
      base_r <= '0;
      start_r <= `SBSP_BURST_RST;
      step_r <= `SBSP_BURST_RST;
      sel_r <= 1'b0;
      first_r <= 1'b0;
      burst_ctrl_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      base_r <= base_nxt;
      start_r <= start_nxt;
      step_r <= step_nxt;
      sel_r <= sel_nxt;
      first_r <= first_nxt;
      burst_ctrl_r <= burst_ctrl_nxt;
    end
  end

  // Write data and enables per lane
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : g_wr
      assign wdata[g*LW +: LW] = {parity_io_i[g], data_io_i[g*BYTE_W +: BYTE_W]};
      assign wen[g] = !sleep_req_i && sel_r && !load &&
                      (!all_bytes_write_n_i || (!byte_write_qual_n_i && !byte_select_n_i[g]));
    end
  endgenerate

  // read the address after any step this edge
  always_comb begin
    if (load) begin
      rd_addr = addr_i;
    end else if (advance) begin
      if (burst_order_i) begin
        rd_addr = {base_r[ADDR_W-1:2], start_r ^ (step_r + `SBSP_BURST_INC)};
      end else begin
        rd_addr = {base_r[ADDR_W-1:2], start_r + step_r + `SBSP_BURST_INC};
      end
    end else begin
      rd_addr = cur_addr;
    end
  end

  sbsp_mem #(
    .AW(ADDR_W),
    .LANES(BYTES),
    .LW(LW)
  ) u_mem (
    .clk_i(ref_clk_i),
    .waddr_i(cur_addr),
    .wen_i(wen),
    .wdata_i(wdata),
    .raddr_i(rd_addr),
    .rdata_o(rdata)
  );

  assign drive = !out_en_n_i && sel_r && !first_r && (cyc_r == sbsp_pkg::SBSP_READ);
  assign data_io_oe_o = drive;
  assign parity_io_oe_o = drive;

  generate
    for (g = 0; g < BYTES; g++) begin : g_rd
      assign data_io_o[g*BYTE_W +: BYTE_W] = rdata[g*LW +: BYTE_W];
      assign parity_io_o[g] = rdata[g*LW + BYTE_W];
    end
  endgenerate

  // Assertions
  // processor strobe wins
  a_strobe_prio_proc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    proc_go |-> !ctrl_go)
    else $error("controller strobe taken with processor strobe");

  a_proc_cs_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (chip_sel_primary_n_i && ctrl_addr_strobe_n_i) |=> $stable(base_r))
    else $error("address loaded while primary select high");

  a_load_counter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    load |=> (step_r == 2'h0) && (start_r == $past(addr_i[1:0])))
    else $error("burst counter not loaded");

  a_ctrl_capture: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ctrl_go |=> base_r == $past(addr_i))
    else $error("controller address not captured");

  a_burst_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    advance |=> step_r == $past(step_r) + 2'h1)
    else $error("burst did not advance");

  a_sleep_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sleep_req_i |-> wen == '0)
    else $error("write during sleep");

  a_float_oe: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    out_en_n_i |-> !data_io_oe_o && !parity_io_oe_o)
    else $error("driving with output enable high");

  a_float_first: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (load && chip_on && !sel_r) |=> !data_io_oe_o)
    else $error("driving in first cycle after deselect");

  a_all_bytes: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!all_bytes_write_n_i && sel_r && !load && !sleep_req_i) |-> &wen)
    else $error("global write missed a lane");

  a_qual_bytes: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (all_bytes_write_n_i && byte_write_qual_n_i) |-> wen == '0)
    else $error("byte write without qualifier");

  a_linear_wrap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!burst_order_i && sel_r) |-> cur_addr[1:0] == 2'(start_r + step_r))
    else $error("linear order wrong");

  a_write_float: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cyc_r == sbsp_pkg::SBSP_WRITE) |-> !data_io_oe_o)
    else $error("driving during write data phase");

  a_desel_float: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !sel_r |-> !data_io_oe_o)
    else $error("driving while deselected");

  a_parity_oe: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    parity_io_oe_o == data_io_oe_o)
    else $error("parity direction differs from data");

  a_select_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !load |=> sel_r == $past(sel_r))
    else $error("selection changed without a load");

  a_inter_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (burst_order_i && sel_r) |-> cur_addr[1:0] == (start_r ^ step_r))
    else $error("interleaved order wrong");

  a_proc_origin: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    proc_go |=> !burst_ctrl_r)
    else $error("processor load marked as controller load");

  a_sleep_freeze: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sleep_req_i |=> $stable(step_r) && $stable(base_r))
    else $error("address state moved during sleep");

  a_hold_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!load && burst_advance_n_i) |=> $stable(step_r))
    else $error("burst stepped without advance");

  a_proc_capture: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    proc_go |=> base_r == $past(addr_i))
    else $error("processor address not captured");
endmodule : sbsp_port

//--- dv/sbsp_host.sv
`timescale 1ns/1ps
module sbsp_host (
  // Clock
  input wire logic clk_i,
  // Strobes, selects and address
  output logic [4:0] st_o,
  output logic [9:0] addr_o,
  // Write controls and data
  output logic [5:0] wr_o,
  output logic [35:0] wd_o
);
  initial begin
    st_o = 5'h1d;
    addr_o = 10'h0;
    wr_o = 6'h3f;
    wd_o = 36'h0;
  end
  task automatic cyc(input logic [4:0] st, input logic [9:0] a, input logic [5:0] w,
                     input logic [35:0] d);
    @(negedge clk_i);
    st_o = st;
    addr_o = a;
    wr_o = w;
    wd_o = (w[5] & w[4]) ? ~wd_o : d;
    @(posedge clk_i);
  endtask : cyc
endmodule : sbsp_host

//--- dv/test_sync_burst_sram_port.sv
`timescale 1ns/1ps
module test_sync_burst_sram_port;
  localparam logic [4:0] IDL = 5'h1d;
  localparam logic [4:0] PL = 5'h0d;
  localparam logic [4:0] CL = 5'h15;
  localparam logic [4:0] STEP = 5'h19;
  localparam logic [5:0] NW = 6'h3f;
  localparam logic [5:0] ALL = 6'h1f;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sleep = 1'b0;
  logic out_en_n = 1'b0;
  logic order = 1'b0;
  logic [4:0] st;
  logic [9:0] addr;
  logic [5:0] wr;
  logic [35:0] wd;
  logic [31:0] dat_o;
  logic [31:0] d_in;
  logic [3:0] par_o;
  logic [3:0] p_in;
  logic dat_oe;
  logic par_oe;
  logic sleep_o;
  int num_errors = 0;
  int tests_run = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  assign d_in = dat_oe ? dat_o : wd[31:0];
  assign p_in = par_oe ? par_o : wd[35:32];
  sbsp_host i_sbsp_host (.clk_i(ref_clk_i), .st_o(st), .addr_o(addr), .wr_o(wr), .wd_o(wd));
  sbsp_port i_sbsp_port (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr),
    .proc_addr_strobe_n_i(st[4]), .ctrl_addr_strobe_n_i(st[3]), .burst_advance_n_i(st[2]),
    .chip_sel_primary_n_i(st[1]), .chip_sel_expand_hi_i(st[0]), .chip_sel_expand_lo_n_i(1'b0),
    .all_bytes_write_n_i(wr[5]), .byte_write_qual_n_i(wr[4]), .byte_select_n_i(wr[3:0]),
    .burst_order_i(order), .sleep_req_i(sleep), .out_en_n_i(out_en_n),
    .data_io_i(d_in), .data_io_o(dat_o), .data_io_oe_o(dat_oe),
    .parity_io_i(p_in), .parity_io_o(par_o), .parity_io_oe_o(par_oe), .sleep_o(sleep_o));
  function automatic logic [35:0] pat(input logic [9:0] a);
    return {4{a[8:0]}};
  endfunction : pat
  task automatic cy(input logic [4:0] s, input logic [9:0] a, input logic [5:0] w,
                    input logic [35:0] d);
    i_sbsp_host.cyc(s, a, w, d);
  endtask : cy
  task automatic chk_d(input logic [35:0] e);
    tests_run++;
    if ({par_o, dat_o} !== e) begin
      num_errors++;
      $display("[FAIL] %0t data %h exp %h", $time, {par_o, dat_o}, e);
    end
  endtask : chk_d
  task automatic chk_b(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t flag %b exp %b", $time, g, e);
    end
  endtask : chk_b
  task automatic rst(input logic o);
    @(negedge ref_clk_i);
    nrst_i = 1'b0;
    order = o;
    repeat (20) @(posedge ref_clk_i);
    @(negedge ref_clk_i) nrst_i = 1'b1;
    cy(PL, 10'h0, NW, '0);
  endtask : rst
  task automatic t_write;
    for (int a = 4; a < 8; a++) begin
      cy(CL, a[9:0], ALL, pat(a[9:0]));
      #1 chk_b(dat_oe, 1'b0);
      cy(IDL, a[9:0], ALL, pat(a[9:0]));
    end
    $display("write test done");
  endtask : t_write
  task automatic t_burst(input logic o);
    cy(PL, 10'h5, NW, '0);
    #1 chk_d(pat(10'h5));
    chk_b(dat_oe, 1'b1);
    for (int i = 1; i < 5; i++) begin
      cy(STEP, 10'h0, NW, '0);
      #1 chk_d(pat({8'h1, o ? 2'h1 ^ i[1:0] : 2'h1 + i[1:0]}));
    end
    $display("burst test done");
  endtask : t_burst
  task automatic t_byte;
    logic [35:0] e;
    e = pat(10'h6);
    for (int g = 0; g < 4; g += 2) begin
      e[8*g+:8] = 8'hff;
      e[32+g] = 1'b1;
    end
    cy(CL, 10'h6, 6'h2a, '1);
    cy(IDL, 10'h6, 6'h2a, '1);
    out_en_n = 1'b1;
    cy(CL, 10'h7, 6'h30, '0);
    cy(IDL, 10'h7, 6'h30, '0);
    out_en_n = 1'b0;
    cy(PL, 10'h7, NW, '0);
    #1 chk_d(pat(10'h7));
    cy(PL, 10'h6, NW, '0);
    #1 chk_d(e);
    $display("byte test done");
  endtask : t_byte
  task automatic t_prio;
    cy(5'h05, 10'h4, ALL, '0);
    #1 chk_b(dat_oe, 1'b1);
    chk_d(pat(10'h4));
    cy(5'h0f, 10'h7, NW, '0);
    #1 chk_d(pat(10'h4));
    out_en_n = 1'b1;
    #1 chk_b(dat_oe, 1'b0);
    chk_b(par_oe, 1'b0);
    out_en_n = 1'b0;
    $display("priority test done");
  endtask : t_prio
  task automatic t_sleep;
    sleep = 1'b1;
    #1 chk_b(sleep_o, 1'b1);
    cy(CL, 10'h5, ALL, '0);
    cy(IDL, 10'h5, ALL, '0);
    #1 sleep = 1'b0;
    cy(PL, 10'h5, NW, '0);
    #1 chk_d(pat(10'h5));
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_desel;
    cy(5'h14, 10'h5, NW, '0);
    #1 chk_b(dat_oe, 1'b0);
    cy(PL, 10'h5, NW, '0);
    #1 chk_b(dat_oe, 1'b0);
    cy(5'h1e, 10'h0, NW, '0);
    #1 chk_b(dat_oe, 1'b1);
    chk_d(pat(10'h5));
    $display("deselect test done");
  endtask : t_desel
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    rst(1'b0);
    t_write;
    t_burst(1'b0);
    rst(1'b1);
    t_burst(1'b1);
    t_byte;
    t_prio;
    t_sleep;
    t_desel;
    print_verdict;
  end
  initial begin
    #(400 * 50);
    num_errors++;
    print_verdict;
  end
endmodule : test_sync_burst_sram_port
